// ===== core/gpct_regs.vh
// constants for the general-purpose counter/timer channel
// assumes a single 20 MHz core clock and a 32-bit plain register port
`ifndef GPCT_REGS_VH
`define GPCT_REGS_VH

// ***************************************************************
// register byte offsets
// ***************************************************************
`define GPCT_OFF_CTRL     8'h00
`define GPCT_OFF_PINSEL   8'h04
`define GPCT_OFF_PERIOD   8'h08
`define GPCT_OFF_WIDTH    8'h0C
`define GPCT_OFF_COUNT    8'h10
`define GPCT_OFF_STATUS   8'h14
`define GPCT_OFF_SAMPLE   8'h18

// ***************************************************************
// control register fields
// ***************************************************************
`define GPCT_CTRL_MODE_LO 0
`define GPCT_CTRL_MODE_HI 1
`define GPCT_CTRL_CLKSRC  2
`define GPCT_CTRL_GATE_LO 3
`define GPCT_CTRL_GATE_HI 4
`define GPCT_CTRL_POL     5
`define GPCT_CTRL_RETRIG  6
`define GPCT_CTRL_RUN     7
`define GPCT_CTRL_W       8

// ***************************************************************
// pin select fields (three bits each, pins 0..7)
// ***************************************************************
`define GPCT_PIN_CLK_LO   0
`define GPCT_PIN_CLK_HI   2
`define GPCT_PIN_GATE_LO  4
`define GPCT_PIN_GATE_HI  6
`define GPCT_PIN_OUT_LO   8
`define GPCT_PIN_OUT_HI   10
`define GPCT_PIN_W        11

// ***************************************************************
// status fields
// ***************************************************************
`define GPCT_STAT_EN      0
`define GPCT_STAT_BUSY    1
`define GPCT_STAT_ACTIVE  2

// ***************************************************************
// encodings
// ***************************************************************
`define GPCT_MODE_IDLE    2'h0
`define GPCT_MODE_EVENT   2'h1
`define GPCT_MODE_RATE    2'h2
`define GPCT_MODE_ONESHOT 2'h3
`define GPCT_GATE_NONE    2'h0
`define GPCT_GATE_LOW     2'h1
`define GPCT_GATE_HIGH    2'h2

// ***************************************************************
// reset values
// ***************************************************************
`define GPCT_RST_CTRL     8'h20
`define GPCT_RST_PINSEL   11'h000
`define GPCT_RST_PERIOD   32'h0000000A
`define GPCT_RST_WIDTH    32'h00000002

// ***************************************************************
// rates
// ***************************************************************
`define GPCT_CORE_HZ      20000000
`define GPCT_TBASE_HZ     48000000
`define GPCT_EXT_MAX_HZ   10000000

`endif

// ===== core/gpct_top.v
// one 32-bit counter/timer channel with pin routing and register port
// assumes gp_in_i pins are asynchronous; adc_sample_i is on clk_i
//
// The register addresses and the strobed register port were decided locally.

`include "gpct_regs.vh"

module gpct_top (
   input  wire        clk_i,
   input  wire        reset_n_i,
   input  wire [7:0]  addr_i,
   input  wire [31:0] wdata_i,
   input  wire        wr_i,
   input  wire        rd_i,
   output reg  [31:0] rdata_o,
   input  wire [7:0]  gp_in_i,
   input  wire        adc_sample_i,
   output reg  [7:0]  gp_out_o,
   output reg  [7:0]  gp_oe_o
);

   // ************************************************************
   // helpers
   // ************************************************************

   // pick one of eight pins by index
   function fn_pick;
      input [7:0] pins;
      input [2:0] idx;
      begin
         fn_pick = pins[idx];
      end
   endfunction

   // one-hot lane for the output pin
   function [7:0] fn_lane;
      input [2:0] idx;
      begin
         fn_lane = 8'h01 << idx;
      end
   endfunction

   // wrapping increment; the carry out is dropped on purpose so
   // the count rolls over to zero and keeps going
   function [31:0] fn_inc;
      input [31:0] val;
      begin
         fn_inc = val + 32'h00000001;
      end
   endfunction

   // ************************************************************
   // software registers
   // ************************************************************
   reg  [`GPCT_CTRL_W-1:0] ctrl;
   reg  [`GPCT_PIN_W-1:0]  pinsel;
   reg  [31:0]             period;
   reg  [31:0]             width;
   reg  [31:0]             count;
   reg  [31:0]             sample;
   reg                     busy;
   reg                     run_q;

   wire [1:0] mode     = ctrl[`GPCT_CTRL_MODE_HI:`GPCT_CTRL_MODE_LO];
   wire [1:0] gate_typ = ctrl[`GPCT_CTRL_GATE_HI:`GPCT_CTRL_GATE_LO];
   wire       clk_ext  = ctrl[`GPCT_CTRL_CLKSRC];
   wire       pol_high = ctrl[`GPCT_CTRL_POL];
   wire       retrig   = ctrl[`GPCT_CTRL_RETRIG];
   wire       run      = ctrl[`GPCT_CTRL_RUN];
   wire [2:0] clk_pin  = pinsel[`GPCT_PIN_CLK_HI:`GPCT_PIN_CLK_LO];
   wire [2:0] gate_pin = pinsel[`GPCT_PIN_GATE_HI:`GPCT_PIN_GATE_LO];
   wire [2:0] out_pin  = pinsel[`GPCT_PIN_OUT_HI:`GPCT_PIN_OUT_LO];

   // ************************************************************
   // pin synchronisers
   // ************************************************************

   // two stages before any logic; third stage only for edges
   reg  [7:0] pin_meta;
   reg  [7:0] pin_sync;
   reg  [7:0] pin_prev;
   always @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         pin_meta <= 8'h00;
         pin_sync <= 8'h00;
         pin_prev <= 8'h00;
      end else begin
         pin_meta <= gp_in_i;
         pin_sync <= pin_meta;
         pin_prev <= pin_sync;
      end
   end

   // ************************************************************
   // clock source and gate decode
   // ************************************************************

   // external clock rises seen by sampling; the internal base is
   // the core clock itself, so every core cycle counts as one tick
   wire ext_now  = fn_pick(pin_sync, clk_pin);
   wire ext_was  = fn_pick(pin_prev, clk_pin);
   wire ext_rise = ext_now & ~ext_was;
   // each count step needs a tick, so the output repeats once every period ticks
   wire tick     = clk_ext ? ext_rise : 1'b1;

   wire g_now  = fn_pick(pin_sync, gate_pin);
   wire g_was  = fn_pick(pin_prev, gate_pin);
   wire g_rise = g_now & ~g_was;
   wire g_fall = ~g_now & g_was;
   wire run_rise = run & ~run_q;

   // level gating for event and rate modes
   reg  gate_on;
   // edge gating for one-shot: enabling and disabling edges
   reg  gate_go;
   reg  gate_stop;
   always @* begin
      gate_on   = 1'b0;
      gate_go   = 1'b0;
      gate_stop = 1'b0;
      case (gate_typ)
         `GPCT_GATE_NONE: begin
            gate_on = run;
            gate_go = run_rise;
         end
         `GPCT_GATE_LOW: begin
            gate_on   = run & ~g_now;
            gate_go   = run & g_fall;
            gate_stop = g_rise;
         end
         `GPCT_GATE_HIGH: begin
            gate_on   = run & g_now;
            gate_go   = run & g_rise;
            gate_stop = g_fall;
         end
         default: begin
            gate_on = 1'b0;
         end
      endcase
   end

   // ************************************************************
   // pulse shaping
   // ************************************************************

   // a zero period would never wrap; treat it as one cycle
   wire last_phase = (count >= period - 32'h00000001) |
                     (period == 32'h00000000);
   wire pulse_on   = (count < width);

   // one-shot trigger; busy blocks edges unless retrigger is set
   wire os_fire = gate_go & (~busy | retrig);

   // ************************************************************
   // one-shot gate window
   // ************************************************************

   // an enabling edge opens the window, a disabling edge closes
   // it; a pulse in flight is not cut, the window is status only
   reg  os_win;
   reg  next_os_win;
   always @* begin
      next_os_win = os_win;
      if (!run)
         next_os_win = 1'b0;
      else if (gate_go)
         next_os_win = 1'b1;
      else if (gate_stop)
         next_os_win = 1'b0;
   end

   always @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i)
         os_win <= 1'b0;
      else
         os_win <= next_os_win;
   end

   // ************************************************************
   // counter and one-shot state
   // ************************************************************
   reg [31:0] next_count;
   reg        next_busy;
   reg        active;
   always @* begin
      next_count = count;
      next_busy  = busy;
      active     = 1'b0;
      case (mode)
         `GPCT_MODE_EVENT: begin
            // new run starts from zero, a stopped run keeps its value
            if (run_rise)
               next_count = 32'h00000000;
            else if (gate_on && tick)
               next_count = fn_inc(count);
         end
         `GPCT_MODE_RATE: begin
            if (!gate_on) begin
               next_count = 32'h00000000;
            end else begin
               active = pulse_on;
               if (tick)
                  next_count = last_phase ? 32'h00000000 :
                               fn_inc(count);
            end
         end
         `GPCT_MODE_ONESHOT: begin
            // a disabling edge only closes the window; a pulse in
            // flight still completes because gate_stop never reaches the counter
            if (!run) begin
               next_busy  = 1'b0;
               next_count = 32'h00000000;
            end else if (os_fire) begin
               next_busy  = 1'b1;
               next_count = 32'h00000000;
            end else if (busy) begin
               active = pulse_on;
               if (tick) begin
                  if (last_phase) begin
                     next_busy  = 1'b0;
                     next_count = 32'h00000000;
                  end else begin
                     next_count = fn_inc(count);
                  end
               end
            end
         end
         default: begin
            next_count = count;
         end
      endcase
   end

   always @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         count  <= 32'h00000000;
         busy   <= 1'b0;
         run_q  <= 1'b0;
      end else begin
         count <= next_count;
         busy  <= next_busy;
         run_q <= run;
      end
   end

   // ************************************************************
   // acquisition snapshot
   // ************************************************************

   // the strobe is on this clock already, so it needs no
   // synchroniser; the word read back is the count at the strobe
   always @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i)
         sample <= 32'h00000000;
      else if (adc_sample_i)
         sample <= count;
   end

   // ************************************************************
   // pin outputs
   // ************************************************************

   // idle leaves the pin undriven so other output logic owns it;
   // event counting has no pulse to show, so it releases it too
   reg  [7:0] next_oe;
   reg  [7:0] next_out;
   always @* begin
      next_oe  = 8'h00;
      next_out = 8'h00;
      case (mode)
         `GPCT_MODE_RATE,
         `GPCT_MODE_ONESHOT: begin
            next_oe = fn_lane(out_pin);
         end
         default: begin
            next_oe = 8'h00;
         end
      endcase
      if (active == pol_high)
         next_out = fn_lane(out_pin);
   end

   // registered so the pins never see decode glitches
   always @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         gp_out_o <= 8'h00;
         gp_oe_o  <= 8'h00;
      end else begin
         gp_out_o <= next_out;
         gp_oe_o  <= next_oe;
      end
   end

   // ************************************************************
   // register port
   // ************************************************************

   // writes land in the cycle of the strobe; no wait states
   always @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         ctrl   <= `GPCT_RST_CTRL;
         pinsel <= `GPCT_RST_PINSEL;
         period <= `GPCT_RST_PERIOD;
         width  <= `GPCT_RST_WIDTH;
      end else if (wr_i) begin
         case (addr_i)
            `GPCT_OFF_CTRL:   ctrl   <= wdata_i[`GPCT_CTRL_W-1:0];
            `GPCT_OFF_PINSEL: pinsel <= wdata_i[`GPCT_PIN_W-1:0];
            `GPCT_OFF_PERIOD: period <= wdata_i;
            `GPCT_OFF_WIDTH:  width  <= wdata_i;
            default: begin
               ctrl <= ctrl;
            end
         endcase
      end
   end

   // status bits; in one-shot the gate bit shows the edge window
   reg  [2:0] status;
   always @* begin
      status = 3'h0;
      status[`GPCT_STAT_EN]     = (mode == `GPCT_MODE_ONESHOT) ?
                                  os_win : gate_on;
      status[`GPCT_STAT_BUSY]   = busy;
      status[`GPCT_STAT_ACTIVE] = active;
   end

   // read data stand for one cycle only, zero otherwise, so a
   // stale word can never be taken for a fresh answer
   always @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         rdata_o <= 32'h00000000;
      end else if (rd_i) begin
         case (addr_i)
            `GPCT_OFF_CTRL:   rdata_o <= {24'h000000, ctrl};
            `GPCT_OFF_PINSEL: rdata_o <= {21'h000000, pinsel};
            `GPCT_OFF_PERIOD: rdata_o <= period;
            `GPCT_OFF_WIDTH:  rdata_o <= width;
            `GPCT_OFF_COUNT:  rdata_o <= count;
            `GPCT_OFF_STATUS: rdata_o <= {29'h00000000, status};
            `GPCT_OFF_SAMPLE: rdata_o <= sample;
            default: begin
               rdata_o <= 32'h00000000;
            end
         endcase
      end else begin
         rdata_o <= 32'h00000000;
      end
   end

endmodule // gpct_top

// ===== dv/gpct_top_assertions.sv
// port checker for the counter/timer channel
// assumes it is bound to gpct_top and sees only its ports
`include "gpct_regs.vh"
module gpct_chk (
   input wire        clk_i,
   input wire        reset_n_i,
   input wire [7:0]  addr_i,
   input wire [31:0] wdata_i,
   input wire        wr_i,
   input wire        rd_i,
   input wire [31:0] rdata_o,
   input wire [7:0]  gp_out_o,
   input wire [7:0]  gp_oe_o
);
   timeunit 1ns;
   timeprecision 1ns;
   // ******************************************************
   // register port and pin relations
   // ******************************************************
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!reset_n_i);
   sequence s_wr_per;
      wr_i && addr_i == `GPCT_OFF_PERIOD;
   endsequence
   sequence s_rd_per;
      rd_i && addr_i == `GPCT_OFF_PERIOD;
   endsequence
   property p_per_rb;
      s_wr_per ##1 s_rd_per |=> rdata_o == $past(wdata_i, 2);
   endproperty
   a_per_rb: assert property (p_per_rb) else $error("period readback");
   property p_rd_idle;
      !$past(rd_i) |-> rdata_o == 32'h00000000;
   endproperty
   a_rd_idle: assert property (p_rd_idle) else $error("stray read data");
   property p_unmap;
      rd_i && addr_i == 8'hFC |=> rdata_o == 32'h00000000;
   endproperty
   a_unmap: assert property (p_unmap) else $error("unmapped read");
   property p_ctrl_w;
      rd_i && addr_i == `GPCT_OFF_CTRL |=> rdata_o[31:8] == 24'h000000;
   endproperty
   a_ctrl_w: assert property (p_ctrl_w) else $error("control width");
   property p_reset;
      $rose(reset_n_i) |-> gp_oe_o == 8'h00 && rdata_o == 32'h00000000;
   endproperty
   a_reset: assert property (p_reset) else $error("reset outputs");
   property p_idle;
      wr_i && addr_i == `GPCT_OFF_CTRL && wdata_i[1:0] == `GPCT_MODE_IDLE
         |-> ##[1:3] gp_oe_o == 8'h00;
   endproperty
   a_idle: assert property (p_idle) else $error("idle keeps pin");
   property p_oe_one;
      $onehot0(gp_oe_o);
   endproperty
   a_oe_one: assert property (p_oe_one) else $error("two enables");
   property p_out_one;
      $onehot0(gp_out_o);
   endproperty
   a_out_one: assert property (p_out_one) else $error("two lanes");
endmodule // gpct_chk

bind gpct_top gpct_chk u_chk (.clk_i(clk_i), .reset_n_i(reset_n_i),
   .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
   .rdata_o(rdata_o), .gp_out_o(gp_out_o), .gp_oe_o(gp_oe_o));

// ===== dv/gpct_far.sv
// external clock source standing at the channel's input pins
// assumes the bench counts its rising edges through rises_o
module gpct_far (
   input  wire run_i,
   output reg  xclk_o,
   output int  rises_o
);
   timeunit 1ns;
   timeprecision 1ns;
   // ******************************************************
   // 400 ns clock, still at 0 between bursts
   // ******************************************************
   // a high phase is always finished so no runt pulse reaches the pin
   initial begin
      xclk_o = 1'b0;
      rises_o = 0;
      #13;
      forever begin
         #200;
         if (run_i || xclk_o) begin
            xclk_o = ~xclk_o;
            rises_o += xclk_o;
         end
      end
   end
endmodule // gpct_far

// ===== dv/testbench.sv
// self-checking bench for the counter/timer channel
// assumes clock pin 1, gate pin 2, output pin 3
`include "gpct_regs.vh"
module testbench;
   timeunit 1ns;
   timeprecision 1ns;
   reg         clk_i = 1'b0;
   reg         reset_n_i = 1'b0;
   reg  [7:0]  addr_i = 8'h00;
   reg  [31:0] wdata_i = 32'h00000000;
   reg         wr_i = 1'b0;
   reg         rd_i = 1'b0;
   reg         adc_sample_i = 1'b0;
   reg         gate = 1'b0;
   reg         run = 1'b0;
   wire        xclk;
   wire [7:0]  gp_in_i;
   wire [31:0] rdata_o;
   wire [7:0]  gp_out_o;
   wire [7:0]  gp_oe_o;
   int         n_fail = 0;
   int         check_count = 0;
   int         rises;
   int         r0;
   int         h;
   assign gp_in_i = {5'h00, gate, xclk, 1'b0};
   gpct_top dut (.clk_i(clk_i), .reset_n_i(reset_n_i), .addr_i(addr_i),
      .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
      .gp_in_i(gp_in_i), .adc_sample_i(adc_sample_i),
      .gp_out_o(gp_out_o), .gp_oe_o(gp_oe_o));
   gpct_far far (.run_i(run), .xclk_o(xclk), .rises_o(rises));
   initial forever #25 clk_i = ~clk_i;
   // ******************************************************
   // shared tasks
   // ******************************************************
   task chk(input string what, input [31:0] seen, input [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         n_fail++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task test_done;
      $display("checks %0d mismatches %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   task cyc(input int n);
      repeat (n) @(posedge clk_i);
   endtask
   task wr(input [7:0] a, input [31:0] d);
      @(posedge clk_i);
      addr_i <= a;
      wdata_i <= d;
      wr_i <= 1'b1;
      @(posedge clk_i);
      wr_i <= 1'b0;
   endtask
   // read data stand only in the cycle after the strobe
   task rchk(input string what, input [7:0] a, input [31:0] exp);
      @(posedge clk_i);
      addr_i <= a;
      rd_i <= 1'b1;
      @(posedge clk_i);
      rd_i <= 1'b0;
      #1 chk(what, rdata_o, exp);
   endtask
   task hi(input int n);
      h = 0;
      repeat (n) begin
         @(posedge clk_i);
         #1 h += gp_out_o[3];
      end
   endtask
   task setg(input v);
      @(posedge clk_i);
      gate <= v;
   endtask
   // one burst of n link periods, then time for the sync stages
   task ext(input int n);
      r0 = rises;
      @(posedge clk_i);
      run <= 1'b1;
      cyc(n * 8);
      run <= 1'b0;
      cyc(20);
   endtask
   // ******************************************************
   // scenarios
   // ******************************************************
   task t_reset;
      rchk("ctrl", `GPCT_OFF_CTRL, 32'h00000020);
      rchk("period", `GPCT_OFF_PERIOD, 32'h0000000A);
      rchk("width", `GPCT_OFF_WIDTH, 32'h00000002);
      rchk("pinsel", `GPCT_OFF_PINSEL, 32'h00000000);
      rchk("unmapped", 8'hFC, 32'h00000000);
      // write then read with no gap between the strobes
      @(posedge clk_i);
      addr_i <= `GPCT_OFF_PERIOD;
      wdata_i <= 32'h00000007;
      wr_i <= 1'b1;
      @(posedge clk_i);
      wr_i <= 1'b0;
      rd_i <= 1'b1;
      @(posedge clk_i);
      rd_i <= 1'b0;
      #1 chk("period b2b", rdata_o, 32'h00000007);
      $display("t_reset done");
   endtask
   task t_rate;
      wr(`GPCT_OFF_PINSEL, 32'h00000321);
      wr(`GPCT_OFF_PERIOD, 32'h00000004);
      wr(`GPCT_OFF_WIDTH, 32'h00000001);
      wr(`GPCT_OFF_CTRL, 32'h000000A2);
      cyc(10);
      hi(8);
      chk("rate high", h, 2);
      chk("oe lane", gp_oe_o, 8'h08);
      wr(`GPCT_OFF_CTRL, 32'h00000082);
      cyc(10);
      hi(8);
      chk("low pol high", h, 6);
      wr(`GPCT_OFF_CTRL, 32'h000000B2);
      cyc(10);
      hi(8);
      chk("gated off", h, 0);
      setg(1'b1);
      cyc(10);
      hi(8);
      chk("gated on", h, 2);
      $display("t_rate done");
   endtask
   task t_event;
      wr(`GPCT_OFF_CTRL, 32'h00000035);
      wr(`GPCT_OFF_CTRL, 32'h000000B5);
      ext(6);
      rchk("count high", `GPCT_OFF_COUNT, rises - r0);
      setg(1'b0);
      cyc(10);
      ext(3);
      rchk("count held", `GPCT_OFF_COUNT, 32'h00000006);
      @(posedge clk_i);
      adc_sample_i <= 1'b1;
      @(posedge clk_i);
      adc_sample_i <= 1'b0;
      rchk("sample", `GPCT_OFF_SAMPLE, 32'h00000006);
      wr(`GPCT_OFF_CTRL, 32'h0000002D);
      wr(`GPCT_OFF_CTRL, 32'h000000AD);
      ext(4);
      rchk("count low", `GPCT_OFF_COUNT, rises - r0);
      $display("t_event done");
   endtask
   // second rising gate edge falls inside the pulse and must be ignored
   task t_oneshot;
      wr(`GPCT_OFF_PERIOD, 32'h0000001E);
      wr(`GPCT_OFF_WIDTH, 32'h00000014);
      wr(`GPCT_OFF_CTRL, 32'h000000B3);
      cyc(10);
      setg(1'b1);
      // sample every edge while the gate falls and rises again
      fork
         hi(60);
         begin
            cyc(6);
            gate <= 1'b0;
            cyc(7);
            gate <= 1'b1;
         end
      join
      chk("one pulse", h, 20);
      // low-active gate: the falling edge fires one pulse
      wr(`GPCT_OFF_CTRL, 32'h000000AB);
      fork
         hi(40);
         setg(1'b0);
      join
      chk("low one pulse", h, 20);
      wr(`GPCT_OFF_CTRL, 32'h00000020);
      cyc(5);
      chk("idle oe", gp_oe_o, 8'h00);
      $display("t_oneshot done");
   endtask
   initial begin
      #4000000;
      n_fail++;
      $display("timeout");
      test_done;
   end
   initial begin
      cyc(20);
      reset_n_i <= 1'b1;
      t_reset;
      t_rate;
      t_event;
      t_oneshot;
      test_done;
   end
endmodule // testbench
